// ---- tsmx_regs.vh ----
// constants of the debug output multiplexer
`ifndef TSMX_REGS_VH
`define TSMX_REGS_VH
`define TSMX_CMD_DIGITAL     8'h18
`define TSMX_CMD_ANALOG      8'h19
`define TSMX_NV_ENABLE_ADDR  8'h17
`define TSMX_NV_ENABLE_BIT   7
`define TSMX_BANK_TIMER      8'h1d
`define TSMX_BANK_CARD       8'h30
`define TSMX_BANK_TRX        8'h58
`define TSMX_BANK_RXDATA     8'h70
`define TSMX_BANK_RXERR      8'h73
`define TSMX_GRP_NONE        3'h0
`define TSMX_GRP_TIMER       3'h1
`define TSMX_GRP_CARD        3'h2
`define TSMX_GRP_TRX         3'h3
`define TSMX_GRP_RXDATA      3'h4
`define TSMX_GRP_RXERR       3'h5
`define TSMX_MASK_TIMER      8'hfc
`define TSMX_MASK_FULL       8'hff
`define TSMX_MASK_RXERR      8'hc7
`define TSMX_SEL_RFCLK       4'h8
`define TSMX_POS_MAX         3'h4
`define TSMX_PIN_IRQ         4'h0
`define TSMX_PIN_FIRST_AUXILIARY_PIN        4'h1
`define TSMX_PIN_SECOND_AUXILIARY_PIN        4'h2
`define TSMX_PIN_GPO         4'h3
`define TSMX_ANA_MAX         8'h0a
`define TSMX_ANA_RESERVED    8'h08
`endif

// ---- tsmx_pin.v ----
// one output pin: its stored route and registered signal choice
`timescale 1ns/1ps
`include "tsmx_regs.vh"
module tsmx_pin (
   input  wire       clk_sys,
   input  wire       rst_n,
   input  wire       load_dig,
   input  wire [2:0] load_grp,
   input  wire [3:0] load_sel,
   input  wire       load_ana,
   input  wire       enable,
   input  wire       rf_clk,
   input  wire [7:0] timer_dbg,
   input  wire [7:0] card_dbg,
   input  wire [7:0] trx_dbg,
   input  wire [7:0] rxdata_dbg,
   input  wire [7:0] rxerr_dbg,
   output reg        pin_q_reg,
   output reg        pin_oe_reg
);
   reg  [2:0] grp_reg;
   reg  [3:0] sel_reg;
   reg        dig_reg;
   reg  [7:0] vec;
   reg  [7:0] mask;
   reg        pin_next;

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         grp_reg <= `TSMX_GRP_NONE;
         sel_reg <= 4'h0;
         dig_reg <= 1'b0;
      end else if (load_dig) begin
         grp_reg <= load_grp;
         sel_reg <= load_sel;
         dig_reg <= 1'b1;
      end else if (load_ana) begin
         dig_reg <= 1'b0;
      end
   end

   always @* begin
      vec  = 8'h00;
      mask = 8'h00;
      case (grp_reg)
         `TSMX_GRP_TIMER: begin
            vec  = timer_dbg;
            mask = `TSMX_MASK_TIMER;
         end
         `TSMX_GRP_CARD: begin
            vec  = card_dbg;
            mask = `TSMX_MASK_FULL;
         end
         `TSMX_GRP_TRX: begin
            vec  = trx_dbg;
            mask = `TSMX_MASK_FULL;
         end
         `TSMX_GRP_RXDATA: begin
            vec  = rxdata_dbg;
            mask = `TSMX_MASK_FULL;
         end
         `TSMX_GRP_RXERR: begin
            vec  = rxerr_dbg;
            mask = `TSMX_MASK_RXERR;
         end
         default: begin
            vec  = 8'h00;
            mask = 8'h00;
         end
      endcase
      if (grp_reg == `TSMX_GRP_NONE)
         pin_next = 1'b0;
      else if (sel_reg == `TSMX_SEL_RFCLK)
         pin_next = rf_clk;
      else if (sel_reg[3])
         pin_next = 1'b0;
      else
         pin_next = vec[sel_reg[2:0]] & mask[sel_reg[2:0]];
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_q_reg  <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else begin
         pin_q_reg  <= enable & dig_reg & pin_next;
         pin_oe_reg <= enable & dig_reg;
      end
   end
endmodule // tsmx_pin

// ---- tsmx_mux.v ----
// debug output multiplexer: command parser, enable gate and four pin routes
// Notes on behaviour
// - select 8 routes recovered carrier clock
// - timer group: run/expiry flags, 1-0 reserved
// - card-mode group maps eight protocol flags
// - transceive 7/6: prefetch done and request
// - transceive 5..0: start, rx enable, state
// - receiver data 7..4: processor indications
// - receiver data 3..0: status, reset, bitclk
// - receiver error group, 5..3 reserved
// - analog command 0x19: second then first aux
// - no output unless nonvolatile enable set
// - analog codes 0..a, 8 reserved
// - digital command 0x18, group, 1-4 positions
// - position byte: low select, high pin
// - group byte values select the five groups
// - enable only when bit 7 set
`timescale 1ns/1ps
`include "tsmx_regs.vh"
module tsmx_mux (
   input  wire       clk_sys,
   input  wire       rst_n,
   input  wire       cmd_valid,
   input  wire       cmd_first,
   input  wire [7:0] cmd_byte,
   input  wire       cmd_end,
   input  wire [7:0] nv_enable_byte,
   input  wire       rf_clk_pin,
   input  wire [7:0] timer_dbg,
   input  wire [7:0] card_dbg,
   input  wire [7:0] trx_dbg,
   input  wire [7:0] rxdata_dbg,
   input  wire [7:0] rxerr_dbg,
   output wire [3:0] dbg_pin_q,
   output wire [3:0] dbg_pin_oe,
   output reg        busy_reg,
   output reg  [3:0] first_aux_ana_sel_reg,
   output reg        first_aux_ana_en_reg,
   output reg  [3:0] second_aux_ana_sel_reg,
   output reg        second_aux_ana_en_reg
);
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_GROUP = 3'h1;
   localparam [2:0] ST_POS   = 3'h2;
   localparam [2:0] ST_ANA1  = 3'h3;
   localparam [2:0] ST_ANA2  = 3'h4;
   localparam [2:0] ST_SKIP  = 3'h5;

   reg  [2:0] state_reg;
   reg  [2:0] grp_reg;
   reg  [2:0] pos_cnt_reg;
   reg  [7:0] ana2_reg;
   reg        enable_reg;
   reg  [2:0] rf_sync_reg;
   reg        rf_clk_reg;
   reg  [2:0] byte_grp;
   wire       pos_load;
   wire       ana_load;
   wire [3:0] pin_code;
   wire       ana1_ok;
   wire       ana2_ok;

   // rf clock comes from another domain; level taken once stages 2 and 3 agree
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         rf_sync_reg <= 3'h0;
         rf_clk_reg  <= 1'b0;
      end else begin
         rf_sync_reg <= {rf_sync_reg[1:0], rf_clk_pin};
         if (rf_sync_reg[1] == rf_sync_reg[2])
            rf_clk_reg <= rf_sync_reg[2];
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n)
         enable_reg <= 1'b0;
      else
         enable_reg <= nv_enable_byte[`TSMX_NV_ENABLE_BIT];
   end

   always @* begin
      case (cmd_byte)
         `TSMX_BANK_TIMER:  byte_grp = `TSMX_GRP_TIMER;
         `TSMX_BANK_CARD:   byte_grp = `TSMX_GRP_CARD;
         `TSMX_BANK_TRX:    byte_grp = `TSMX_GRP_TRX;
         `TSMX_BANK_RXDATA: byte_grp = `TSMX_GRP_RXDATA;
         `TSMX_BANK_RXERR:  byte_grp = `TSMX_GRP_RXERR;
         default:           byte_grp = `TSMX_GRP_NONE;
      endcase
   end

   assign pos_load = cmd_valid & ~cmd_first & (state_reg == ST_POS);
   assign ana_load = cmd_valid & ~cmd_first & (state_reg == ST_ANA2);
   assign pin_code = cmd_byte[7:4];
   // reserved analog codes leave the pin undriven rather than guess a signal
   assign ana2_ok  = (ana2_reg <= `TSMX_ANA_MAX) && (ana2_reg != `TSMX_ANA_RESERVED);
   assign ana1_ok  = (cmd_byte <= `TSMX_ANA_MAX) && (cmd_byte != `TSMX_ANA_RESERVED);

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg   <= ST_IDLE;
         grp_reg     <= `TSMX_GRP_NONE;
         pos_cnt_reg <= 3'h0;
         ana2_reg    <= 8'h00;
         busy_reg    <= 1'b0;
      end else begin
         if (cmd_valid && cmd_first) begin
            busy_reg    <= 1'b0;
            pos_cnt_reg <= 3'h0;
            case (cmd_byte)
               `TSMX_CMD_DIGITAL: state_reg <= ST_GROUP;
               `TSMX_CMD_ANALOG:  state_reg <= ST_ANA1;
               default:           state_reg <= ST_SKIP;
            endcase
         end else if (cmd_valid) begin
            case (state_reg)
               ST_GROUP: begin
                  grp_reg   <= byte_grp;
                  state_reg <= ST_POS;
               end
               ST_POS: begin
                  pos_cnt_reg <= pos_cnt_reg + 3'h1;
                  // a fifth position byte is ignored
                  if (pos_cnt_reg + 3'h1 == `TSMX_POS_MAX)
                     state_reg <= ST_SKIP;
               end
               ST_ANA1: begin
                  ana2_reg  <= cmd_byte;
                  state_reg <= ST_ANA2;
               end
               ST_ANA2:  state_reg <= ST_SKIP;
               ST_SKIP:  state_reg <= ST_SKIP;
               default:  state_reg <= ST_IDLE;
            endcase
         end
         // busy rises when the command frame is complete
         if (cmd_end) begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b1;
         end
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         first_aux_ana_sel_reg  <= 4'h0;
         second_aux_ana_sel_reg <= 4'h0;
         first_aux_ana_en_reg   <= 1'b0;
         second_aux_ana_en_reg  <= 1'b0;
      end else begin
         if (ana_load) begin
            second_aux_ana_sel_reg <= ana2_reg[3:0];
            first_aux_ana_sel_reg  <= cmd_byte[3:0];
            second_aux_ana_en_reg  <= enable_reg & ana2_ok;
            first_aux_ana_en_reg   <= enable_reg & ana1_ok;
         end else begin
            if (pos_load && pin_code == `TSMX_PIN_FIRST_AUXILIARY_PIN)
               first_aux_ana_en_reg <= 1'b0;
            else if (!enable_reg)
               first_aux_ana_en_reg <= 1'b0;
            if (pos_load && pin_code == `TSMX_PIN_SECOND_AUXILIARY_PIN)
               second_aux_ana_en_reg <= 1'b0;
            else if (!enable_reg)
               second_aux_ana_en_reg <= 1'b0;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
         tsmx_pin u_pin (
            .clk_sys    (clk_sys),
            .rst_n      (rst_n),
            .load_dig   (pos_load && pin_code == gi),
            .load_grp   (grp_reg),
            .load_sel   (cmd_byte[3:0]),
            .load_ana   (ana_load && (gi == 1 || gi == 2)),
            .enable     (enable_reg),
            .rf_clk     (rf_clk_reg),
            .timer_dbg  (timer_dbg),
            .card_dbg   (card_dbg),
            .trx_dbg    (trx_dbg),
            .rxdata_dbg (rxdata_dbg),
            .rxerr_dbg  (rxerr_dbg),
            .pin_q_reg  (dbg_pin_q[gi]),
            .pin_oe_reg (dbg_pin_oe[gi])
         );
      end
   endgenerate
endmodule // tsmx_mux

// ---- tsmx_mux_properties.sv ----
// port checker for the debug output multiplexer
`timescale 1ns/1ps
`include "tsmx_regs.vh"
module tsmx_mux_chk (
   input wire       clk_sys,
   input wire       rst_n,
   input wire       cmd_valid,
   input wire       cmd_first,
   input wire [7:0] cmd_byte,
   input wire       cmd_end,
   input wire [7:0] nv_enable_byte,
   input wire [7:0] timer_dbg,
   input wire [7:0] card_dbg,
   input wire [7:0] trx_dbg,
   input wire [7:0] rxdata_dbg,
   input wire [7:0] rxerr_dbg,
   input wire [3:0] dbg_pin_q,
   input wire [3:0] dbg_pin_oe,
   input wire       busy_reg,
   input wire [3:0] first_aux_ana_sel_reg,
   input wire       first_aux_ana_en_reg
);
   reg  [2:0] cnt_reg;
   reg  [7:0] grp_reg;
   reg  [3:0] sel_reg;
   reg  [1:0] pin_reg;
   reg        take_reg;
   wire       en = nv_enable_byte[`TSMX_NV_ENABLE_BIT];
   wire       arg = cmd_valid && !cmd_first;
   wire       pos = arg && cnt_reg > 3'd1 && cnt_reg < 3'd6 && cmd_byte[7:6] == 2'h0;
   // reserved selects masked to low, unknown group reads all low
   wire [7:0] bus = grp_reg == `TSMX_BANK_TIMER ? timer_dbg & `TSMX_MASK_TIMER :
                    grp_reg == `TSMX_BANK_CARD ? card_dbg :
                    grp_reg == `TSMX_BANK_TRX ? trx_dbg :
                    grp_reg == `TSMX_BANK_RXDATA ? rxdata_dbg :
                    grp_reg == `TSMX_BANK_RXERR ? rxerr_dbg & `TSMX_MASK_RXERR : 8'h00;
   always @(posedge clk_sys) begin
      if (!rst_n || (cmd_valid && cmd_first))
         cnt_reg <= {2'h0, rst_n && cmd_byte == `TSMX_CMD_DIGITAL};
      else if (arg && cnt_reg != 3'd0 && cnt_reg != 3'd6)
         cnt_reg <= cnt_reg + 3'd1;
      if (arg && cnt_reg == 3'd1)
         grp_reg <= cmd_byte;
      take_reg <= rst_n && pos && en && cmd_byte[3:0] != `TSMX_SEL_RFCLK;
      sel_reg <= cmd_byte[3:0];
      pin_reg <= cmd_byte[5:4];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_busy_on_end: assert property (cmd_end && !cmd_first |=> busy_reg)
      else $error("busy late");
   a_busy_cleared: assert property (cmd_valid && cmd_first && !cmd_end |=> !busy_reg)
      else $error("busy not cleared");
   a_busy_held: assert property (busy_reg && !cmd_first |=> busy_reg)
      else $error("busy dropped");
   a_quiet_when_off: assert property (!en [*3] |->
      dbg_pin_oe == 4'h0 && dbg_pin_q == 4'h0 && !first_aux_ana_en_reg)
      else $error("output while disabled");
   a_oe_needs_en: assert property (dbg_pin_oe != 4'h0 |-> $past(en))
      else $error("oe without enable");
   a_route_follows: assert property (take_reg |=>
      dbg_pin_oe[$past(pin_reg)] && dbg_pin_q[$past(pin_reg)] == $past(!sel_reg[3] && bus[sel_reg[2:0]]))
      else $error("pin route wrong");
   a_fifth_ignored: assert property (arg && cnt_reg == 3'd6 |-> ##2 $stable(dbg_pin_oe))
      else $error("fifth position taken");
   a_ana_code_valid: assert property (first_aux_ana_en_reg |->
      first_aux_ana_sel_reg <= 4'ha && first_aux_ana_sel_reg != 4'h8)
      else $error("analog code invalid");
endmodule // tsmx_mux_chk
bind tsmx_mux tsmx_mux_chk u_chk (.*);

// ---- tsmx_host.sv ----
// host model: sends command frames and waits on busy
`timescale 1ns/1ps
module tsmx_host (
   input  wire       clk_sys,
   input  wire       busy_reg,
   output reg        cmd_valid = 1'b0,
   output reg        cmd_first = 1'b0,
   output reg  [7:0] cmd_byte = 8'h00,
   output reg        cmd_end = 1'b0
);
   // bytes back to back, code byte first
   task send(input [63:0] frm, input integer n);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1) begin
            @(posedge clk_sys);
            cmd_valid <= 1'b1;
            cmd_first <= k == 0;
            cmd_byte <= frm[63 - 8 * k -: 8];
            cmd_end <= k == n - 1;
         end
         @(posedge clk_sys);
         cmd_valid <= 1'b0;
         cmd_first <= 1'b0;
         cmd_end <= 1'b0;
         cmd_byte <= ~cmd_byte; // idle lane never shows the last byte
         // no next frame before busy is seen high or 8 cycles have passed
         for (k = 0; k < 8 && busy_reg !== 1'b1; k = k + 1)
            @(negedge clk_sys);
         @(negedge clk_sys);
      end
   endtask
endmodule // tsmx_host

// ---- tsmx_mux_tb.sv ----
// self-checking bench for the debug output multiplexer
`timescale 1ns/1ps
module tsmx_mux_tb;
   reg         clk_sys = 1'b0;
   reg         rst_n = 1'b0;
   reg  [7:0]  nv = 8'h7f;
   reg         rf = 1'b1;
   reg  [7:0]  pat = 8'hff;
   reg  [7:0]  tpat = 8'hff;
   wire        cmd_valid, cmd_first, cmd_end, busy_reg, e1, e2;
   wire [7:0]  cmd_byte;
   wire [3:0]  q, oe, s1, s2;
   reg  [24:0] rows [0:9];
   integer     err_count = 0;
   integer     n_tests = 0;
   integer     i;
   always #20 clk_sys = ~clk_sys;
   tsmx_mux dut (.*, .nv_enable_byte(nv), .rf_clk_pin(rf), .timer_dbg(tpat), .card_dbg(pat),
      .trx_dbg(pat), .rxdata_dbg(pat), .rxerr_dbg(pat), .dbg_pin_q(q), .dbg_pin_oe(oe),
      .first_aux_ana_sel_reg(s1), .first_aux_ana_en_reg(e1),
      .second_aux_ana_sel_reg(s2), .second_aux_ana_en_reg(e2));
   tsmx_host host (.*);
   task check(input [23:0] got, input [23:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task finish_test;
      begin
         $display("%0d checks, %0d errors", n_tests, err_count);
         if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task route(input [15:0] gp);
      begin
         host.send({8'h18, gp, 40'h0}, 3);
         check(busy_reg, 1'b1);
         repeat (2) @(negedge clk_sys);
      end
   endtask
   initial begin
      #200000;
      err_count = err_count + 1;
      finish_test;
   end
   initial begin
      rows[0] = {24'h1d0780, 1'b1};
      rows[1] = {24'h1d11ff, 1'b0};
      rows[2] = {24'h302520, 1'b1};
      rows[3] = {24'h583640, 1'b1};
      rows[4] = {24'h582308, 1'b1};
      rows[5] = {24'h701410, 1'b1};
      rows[6] = {24'h702102, 1'b1};
      rows[7] = {24'h730640, 1'b1};
      rows[8] = {24'h7329ff, 1'b0};
      rows[9] = {24'h581800, 1'b1};
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      check({q, oe, busy_reg, s1, e1, s2, e2}, 24'h0);
      route(16'h1d07);
      check({q, oe}, 8'h00);
      @(posedge clk_sys);
      nv <= 8'h80;
      for (i = 0; i < 10; i = i + 1) begin
         @(posedge clk_sys);
         pat <= rows[i][8:1];
         tpat <= rows[i][8:1];
         route(rows[i][24:9]);
         check({q[rows[i][14:13]], oe[rows[i][14:13]]}, {rows[i][0], 1'b1});
      end
      $display("rows done");
      @(posedge clk_sys);
      tpat <= 8'h80;
      pat <= 8'h00;
      host.send(64'h181d071727370200, 7);
      repeat (2) @(negedge clk_sys);
      check({q, oe}, 8'hff);
      route(16'h3007);
      check({q, oe}, 8'hef);
      $display("multi done");
      for (i = 0; i < 12; i = i + 1) begin
         host.send({8'h19, i[7:0], 8'h0a - i[7:0], 40'h0}, 3);
         check({e2, e1}, {i != 8 && i < 11, i != 2 && i < 11});
         if (i < 11 && i != 2 && i != 8)
            check({s2, s1}, {i[3:0], 4'ha - i[3:0]});
      end
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      check({q, oe, busy_reg, s1, e1, s2, e2}, 24'h0);
      $display("analog done");
      finish_test;
   end
endmodule // tsmx_mux_tb
